// *** hdl/tws_defs.svh ***
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
// How it works
// - ack_value bit drives sent acknowledge level
// - ack_seq_request sends acknowledge, then self-clears
// - master_rx_request clocks one byte, clears after eighth
// - stop_request makes Stop, clears when done
// - restart_request makes Repeated Start, then clears
// - start_request makes Start, clears when done
// - last_ack_seen holds last acknowledge level
// - master_tx_active spans eight bits plus acknowledge
// - collision_flag sets on master collision, software clears
// - general_call_seen sets on general call, Stop clears
// - ten_bit_matched sets on second byte, Stop clears
// - busy transmit write dropped, sets write collision
// - receive into full buffer sets overflow flag
// - data-address flag: clear on match, set on data
// - stop and start flags track last condition
// - slave direction flag taken from address read bit
// - rx_full sets on receive, clears on read
// - tx_full sets on write, clears after sending
// - ten mask bits make address bits don't-care
// - long_input_delay picks 300 ns, else 150 ns
// - unimplemented status and mask bits read zero
// - reserved addresses other than general call match only when accept-all is set
// - general call acknowledged only when enabled or accept-all set

// ==========================================
// register byte addresses
`define TWS_ADDR_CONTROL 5'h00
`define TWS_ADDR_STATUS 5'h04
`define TWS_ADDR_MASK 5'h08
`define TWS_ADDR_PAD 5'h0C
`define TWS_ADDR_TXBUF 5'h10
`define TWS_ADDR_RXBUF 5'h14
`define TWS_ADDR_OWNADDR 5'h18
`define TWS_ADDR_BAUD 5'h1C

// ==========================================
// control bit positions
`define TWS_CON_ENABLE 15
`define TWS_CON_ACCEPT_ALL 11
`define TWS_CON_TEN_BIT 10
`define TWS_CON_GC_EN 7
`define TWS_CON_ACK_VALUE 5
`define TWS_CON_ACK_SEQ 4
`define TWS_CON_RX_REQ 3
`define TWS_CON_STOP_REQ 2
`define TWS_CON_RESTART_REQ 1
`define TWS_CON_START_REQ 0
`define TWS_CON_WMASK 16'h8CA0
`define TWS_PAD_LONG_DELAY 4
`define TWS_MASK_WIDTH 10

// ==========================================
// reset values and timing
`define TWS_BAUD_RESET 8'h3F
`define TWS_CLK_MHZ 100
`define TWS_LONG_DELAY_NS 300
`define TWS_SHORT_DELAY_NS 150
`define TWS_LONG_DELAY_CYC ((`TWS_LONG_DELAY_NS * `TWS_CLK_MHZ) / 1000)
`define TWS_SHORT_DELAY_CYC ((`TWS_SHORT_DELAY_NS * `TWS_CLK_MHZ) / 1000)
`endif

// *** hdl/tws_pkg.sv ***
package tws_pkg;
	// master sequencer states, one-hot
	typedef enum logic [6:0] {
		TWS_IDLE = 7'h01,
		TWS_START = 7'h02,
		TWS_RESTART = 7'h04,
		TWS_STOP = 7'h08,
		TWS_TXBIT = 7'h10,
		TWS_RXBIT = 7'h20,
		TWS_ACKBIT = 7'h40
	} tws_state_e;
endpackage

// *** hdl/tws_ctrl.sv ***
`timescale 1ns/1ps
`include "tws_defs.svh"
module tws_ctrl (
	// system
	input wire logic clock,
	input wire logic arst_n,
	// avalon-mm slave
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// two-wire pins, three signals each
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe
);
	import tws_pkg::*;

	// ==========================================
	// registers
	logic [15:0] con_ff; // control bits
	logic [9:0] mask_ff; // address don't-care bits
	logic long_delay_ff; // input delay select
	logic [9:0] own_addr_ff; // own slave address
	logic [7:0] baud_ff; // bit-phase period in cycles minus one; a bit takes three phases
	logic [7:0] tx_buf_ff;
	logic [7:0] rx_buf_ff;
	logic last_ack_ff, tx_active_ff, coll_ff, gc_ff, ten_ff;
	logic wcol_ff, ovf_ff, da_ff, stop_seen_ff, start_seen_ff, dir_ff;
	logic rx_full_ff, tx_full_ff;
	logic ack_ff; // bus answer registered for one wait state
	logic sl_ack_ff; // slave pulls data low for its acknowledge
	logic [31:0] rdata_ff;

	// ==========================================
	// pin synchronisers: three stages, change once 2nd and 3rd agree
	logic [2:0] scl_sy_ff, sda_sy_ff;
	logic scl_ff, sda_raw_ff, scl_q_ff;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			scl_sy_ff <= 3'h7;
			sda_sy_ff <= 3'h7;
			scl_ff <= 1'b1;
			sda_raw_ff <= 1'b1;
			scl_q_ff <= 1'b1;
		end else begin
			scl_sy_ff <= {scl_sy_ff[1:0], serial_clock_pin_in};
			sda_sy_ff <= {sda_sy_ff[1:0], serial_data_pin_in};
			if (scl_sy_ff[1] == scl_sy_ff[2]) begin
				scl_ff <= scl_sy_ff[2];
			end
			if (sda_sy_ff[1] == sda_sy_ff[2]) begin
				sda_raw_ff <= sda_sy_ff[2];
			end
			scl_q_ff <= scl_ff;
		end
	end

	// ==========================================
	// data input delay line; length chosen by the pad setting
	logic [`TWS_LONG_DELAY_CYC-1:0] sda_dly_ff;
	logic sda_ff, sda_q_ff;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sda_dly_ff <= '1;
			sda_q_ff <= 1'b1;
		end else begin
			sda_dly_ff <= {sda_dly_ff[`TWS_LONG_DELAY_CYC-2:0], sda_raw_ff};
			sda_q_ff <= sda_ff;
		end
	end
	assign sda_ff = long_delay_ff ? sda_dly_ff[`TWS_LONG_DELAY_CYC-1]
		: sda_dly_ff[`TWS_SHORT_DELAY_CYC-1];

	// bus event decode
	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise = scl_ff & ~scl_q_ff;
	assign scl_fall = ~scl_ff & scl_q_ff;
	assign start_det = scl_ff & scl_q_ff & sda_q_ff & ~sda_ff;
	assign stop_det = scl_ff & scl_q_ff & ~sda_q_ff & sda_ff;

	// ==========================================
	// bus access decode: one wait state per access
	logic acc, wr_acc, rd_acc;
	assign acc = (read | write) & ~ack_ff;
	assign waitrequest = (read | write) & ~ack_ff;
	assign wr_acc = write & ack_ff;
	assign rd_acc = read & ack_ff;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= acc;
		end
	end

	// ==========================================
	// master sequencer
	tws_state_e state_ff;
	logic [7:0] tick_ff; // bit-phase timer, one third of a data bit
	logic [1:0] phase_ff; // step within a condition (up to four) or a bit (three)
	logic [2:0] bit_ff; // bit count within a byte
	logic [7:0] sh_ff; // master shift register
	logic drv_scl_ff, drv_sda_ff; // 1 = pull pin low
	logic m_done, tick;
	logic busy;
	assign tick = (tick_ff == 8'h00);
	assign busy = (state_ff != TWS_IDLE) | (|con_ff[4:0]);
	// one pass through a condition step
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tick_ff <= 8'h00;
		end else if (tick || state_ff == TWS_IDLE) begin
			tick_ff <= baud_ff;
		end else begin
			tick_ff <= tick_ff - 8'h01;
		end
	end

	logic tx_load;
	assign tx_load = wr_acc && address == `TWS_ADDR_TXBUF && !busy && !tx_full_ff;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= TWS_IDLE;
			phase_ff <= 2'h0;
			bit_ff <= 3'h0;
			sh_ff <= 8'h00;
			drv_scl_ff <= 1'b0;
			drv_sda_ff <= 1'b0;
		end else if (!con_ff[`TWS_CON_ENABLE] || coll_ff) begin
			// collision or disable: release lines, abandon sequence
			state_ff <= TWS_IDLE;
			drv_scl_ff <= 1'b0;
			drv_sda_ff <= 1'b0;
		end else begin
			case (state_ff)
				TWS_IDLE: begin
					phase_ff <= 2'h0;
					bit_ff <= 3'h7;
					// requests are taken in fixed priority
					if (con_ff[`TWS_CON_START_REQ]) state_ff <= TWS_START;
					else if (con_ff[`TWS_CON_RESTART_REQ]) state_ff <= TWS_RESTART;
					else if (con_ff[`TWS_CON_STOP_REQ]) state_ff <= TWS_STOP;
					else if (con_ff[`TWS_CON_RX_REQ]) state_ff <= TWS_RXBIT;
					else if (con_ff[`TWS_CON_ACK_SEQ]) state_ff <= TWS_ACKBIT;
					else if (tx_load) begin
						sh_ff <= writedata[7:0];
						state_ff <= TWS_TXBIT;
					end
				end
				TWS_START: if (tick) begin
					phase_ff <= phase_ff + 2'h1;
					if (phase_ff == 2'h0) drv_sda_ff <= 1'b1;
					if (phase_ff == 2'h1) begin
						drv_scl_ff <= 1'b1;
						state_ff <= TWS_IDLE;
					end
				end
				TWS_RESTART: if (tick) begin
					phase_ff <= phase_ff + 2'h1;
					case (phase_ff)
						2'h0: drv_sda_ff <= 1'b0;
						2'h1: drv_scl_ff <= 1'b0;
						2'h2: drv_sda_ff <= 1'b1;
						default: begin
							drv_scl_ff <= 1'b1;
							state_ff <= TWS_IDLE;
						end
					endcase
				end
				TWS_STOP: if (tick) begin
					phase_ff <= phase_ff + 2'h1;
					case (phase_ff)
						2'h0: drv_sda_ff <= 1'b1;
						2'h1: drv_scl_ff <= 1'b0;
						2'h2: drv_sda_ff <= 1'b0;
						default: state_ff <= TWS_IDLE;
					endcase
				end
				TWS_TXBIT, TWS_RXBIT: if (tick) begin
					phase_ff <= phase_ff + 2'h1;
					case (phase_ff)
						2'h0: drv_sda_ff <= (state_ff == TWS_TXBIT) ? ~sh_ff[bit_ff] : 1'b0;
						2'h1: drv_scl_ff <= 1'b0;
						2'h2: begin
							if (state_ff == TWS_RXBIT) sh_ff[bit_ff] <= sda_ff;
							drv_scl_ff <= 1'b1;
							phase_ff <= 2'h0;
							bit_ff <= bit_ff - 3'h1;
							if (bit_ff == 3'h0) begin
								// transmit goes on to read the slave's acknowledge
								if (state_ff == TWS_TXBIT) state_ff <= TWS_ACKBIT;
								else state_ff <= TWS_IDLE;
							end
						end
						default: phase_ff <= 2'h0;
					endcase
				end
				TWS_ACKBIT: if (tick) begin
					phase_ff <= phase_ff + 2'h1;
					case (phase_ff)
						2'h0: drv_sda_ff <= tx_active_ff ? 1'b0 : ~con_ff[`TWS_CON_ACK_VALUE];
						2'h1: drv_scl_ff <= 1'b0;
						2'h2: begin
							drv_scl_ff <= 1'b1;
							state_ff <= TWS_IDLE;
						end
						default: phase_ff <= 2'h0;
					endcase
				end
				default: state_ff <= TWS_IDLE;
			endcase
		end
	end
	// sequence finishes on the cycle it returns to idle, or after a sent byte moves to the acknowledge
	assign m_done = tick && state_ff != TWS_IDLE && (
		(state_ff == TWS_START && phase_ff == 2'h1) ||
		(state_ff == TWS_STOP && phase_ff == 2'h3) ||
		(state_ff == TWS_RESTART && phase_ff == 2'h3) ||
		(phase_ff == 2'h2 && (state_ff == TWS_ACKBIT ||
		((state_ff == TWS_TXBIT || state_ff == TWS_RXBIT) && bit_ff == 3'h0))));
	logic m_tx_ack_done, m_rx_done, m_collide;
	assign m_tx_ack_done = m_done && state_ff == TWS_ACKBIT && tx_active_ff;
	assign m_rx_done = m_done && state_ff == TWS_RXBIT;
	// released data read low while master drives high
	assign m_collide = state_ff != TWS_IDLE && !drv_sda_ff && scl_rise && !sda_ff
		&& (state_ff == TWS_TXBIT || state_ff == TWS_START);

	// open-drain outputs: only ever pull low
	assign serial_clock_pin_out = 1'b0;
	assign serial_clock_pin_oe = drv_scl_ff;
	assign serial_data_pin_out = 1'b0;
	assign serial_data_pin_oe = drv_sda_ff | sl_ack_ff;

	// ==========================================
	// slave address receiver (listens to every byte)
	logic [8:0] sl_sh_ff; // byte plus ack slot count
	logic [3:0] sl_cnt_ff;
	logic sl_first_ff; // next byte is an address byte
	logic sl_hi_ff; // upper ten-bit byte matched
	logic sl_byte, addr_hit7, addr_hi10, addr_lo10, reserved, gc_hit;
	logic [7:0] sl_byte_v;
	assign sl_byte_v = sl_sh_ff[7:0];
	assign sl_byte = scl_rise && sl_cnt_ff == 4'h7;
	logic [7:0] nb;
	assign nb = {sl_sh_ff[6:0], sda_ff};
	assign reserved = (nb[7:3] == 5'h00) || (nb[7:3] == 5'h1F)
		|| (nb[7:3] == 5'h1E && !con_ff[`TWS_CON_TEN_BIT]);
	assign gc_hit = nb == 8'h00 && con_ff[`TWS_CON_GC_EN];
	assign addr_hit7 = con_ff[`TWS_CON_ACCEPT_ALL] || (!reserved &&
		((((nb[7:1] ^ own_addr_ff[6:0]) & ~mask_ff[6:0]) == 7'h00)));
	assign addr_hi10 = nb[7:3] == 5'h1E &&
		(((nb[2:1] ^ own_addr_ff[9:8]) & ~mask_ff[9:8]) == 2'h0);
	assign addr_lo10 = sl_hi_ff && (((nb ^ own_addr_ff[7:0]) & ~mask_ff[7:0]) == 8'h00);
	logic sl_match;
	assign sl_match = sl_byte && sl_first_ff && state_ff == TWS_IDLE &&
		(con_ff[`TWS_CON_TEN_BIT] ? (addr_hi10 || addr_lo10) : (addr_hit7 || gc_hit));

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sl_sh_ff <= 9'h000;
			sl_cnt_ff <= 4'h0;
			sl_first_ff <= 1'b1;
			sl_hi_ff <= 1'b0;
			sl_ack_ff <= 1'b0;
		end else if (start_det || stop_det) begin
			sl_cnt_ff <= 4'h0;
			sl_first_ff <= 1'b1;
			sl_hi_ff <= 1'b0;
			sl_ack_ff <= 1'b0;
		end else begin
			if (scl_rise) begin
				sl_sh_ff <= {sl_sh_ff[7:0], sda_ff};
				sl_cnt_ff <= (sl_cnt_ff == 4'h8) ? 4'h0 : sl_cnt_ff + 4'h1;
			end
			if (sl_match) begin
				sl_ack_ff <= 1'b1;
				sl_hi_ff <= con_ff[`TWS_CON_TEN_BIT] && !sl_hi_ff;
				sl_first_ff <= con_ff[`TWS_CON_TEN_BIT] && !sl_hi_ff;
			end else if (sl_byte) begin
				sl_first_ff <= 1'b0;
			end
			if (scl_fall && sl_cnt_ff == 4'h0) sl_ack_ff <= 1'b0;
		end
	end

	// ==========================================
	// status flags; hardware set wins over software clear
	logic sw_stat, sw_rx_read;
	assign sw_stat = wr_acc && address == `TWS_ADDR_STATUS;
	assign sw_rx_read = rd_acc && address == `TWS_ADDR_RXBUF;
	logic rx_store, sl_data_byte;
	// bytes of our own master traffic are not slave data
	assign sl_data_byte = sl_byte && !sl_first_ff && state_ff == TWS_IDLE;
	assign rx_store = m_rx_done || sl_data_byte;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{last_ack_ff, tx_active_ff, coll_ff, gc_ff, ten_ff} <= 5'h00;
			{wcol_ff, ovf_ff, da_ff, stop_seen_ff, start_seen_ff} <= 5'h00;
			{dir_ff, rx_full_ff, tx_full_ff} <= 3'h0;
			rx_buf_ff <= 8'h00;
			tx_buf_ff <= 8'h00;
		end else begin
			if (scl_rise && state_ff == TWS_ACKBIT && phase_ff == 2'h2)
				last_ack_ff <= sda_ff;
			if (tx_load) tx_active_ff <= 1'b1;
			else if (m_tx_ack_done) tx_active_ff <= 1'b0;
			if (m_collide) coll_ff <= 1'b1;
			else if (sw_stat && !writedata[10]) coll_ff <= 1'b0;
			if (sl_match && nb == 8'h00) gc_ff <= 1'b1;
			else if (stop_det) gc_ff <= 1'b0;
			if (sl_match && sl_hi_ff) ten_ff <= 1'b1;
			else if (stop_det) ten_ff <= 1'b0;
			if (wr_acc && address == `TWS_ADDR_TXBUF && !tx_load)
				wcol_ff <= 1'b1;
			else if (sw_stat && !writedata[7]) wcol_ff <= 1'b0;
			if (rx_store && rx_full_ff) ovf_ff <= 1'b1;
			else if (sw_stat && !writedata[6]) ovf_ff <= 1'b0;
			if (sl_match) da_ff <= 1'b0;
			else if (tx_load || sl_data_byte) da_ff <= 1'b1;
			if (start_det) begin
				start_seen_ff <= 1'b1;
				stop_seen_ff <= 1'b0;
			end else if (stop_det) begin
				start_seen_ff <= 1'b0;
				stop_seen_ff <= 1'b1;
			end
			if (sl_match) dir_ff <= nb[0];
			if (rx_store && !rx_full_ff) begin
				rx_buf_ff <= m_rx_done ? {sh_ff[7:1], sda_ff} : nb;
				rx_full_ff <= 1'b1;
			end else if (sw_rx_read) rx_full_ff <= 1'b0;
			if (tx_load) begin
				tx_buf_ff <= writedata[7:0];
				tx_full_ff <= 1'b1;
			end else if (m_done && state_ff == TWS_TXBIT) tx_full_ff <= 1'b0;
		end
	end

	// ==========================================
	// control and config registers; request bits self-clear
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			con_ff <= 16'h0000;
			mask_ff <= 10'h000;
			long_delay_ff <= 1'b0;
			own_addr_ff <= 10'h000;
			baud_ff <= `TWS_BAUD_RESET;
		end else begin
			if (wr_acc && address == `TWS_ADDR_CONTROL) begin
				// requests only set; hardware alone clears them
				con_ff <= (writedata[15:0] & `TWS_CON_WMASK)
					| {11'h000, con_ff[4:0] | writedata[4:0]};
			end else if (m_done) begin
				case (state_ff)
					TWS_START: con_ff[`TWS_CON_START_REQ] <= 1'b0;
					TWS_RESTART: con_ff[`TWS_CON_RESTART_REQ] <= 1'b0;
					TWS_STOP: con_ff[`TWS_CON_STOP_REQ] <= 1'b0;
					TWS_RXBIT: con_ff[`TWS_CON_RX_REQ] <= 1'b0;
					TWS_ACKBIT: con_ff[`TWS_CON_ACK_SEQ] <= 1'b0;
					default: con_ff <= con_ff;
				endcase
			end
			if (wr_acc && address == `TWS_ADDR_MASK) mask_ff <= writedata[9:0];
			if (wr_acc && address == `TWS_ADDR_PAD)
				long_delay_ff <= writedata[`TWS_PAD_LONG_DELAY];
			if (wr_acc && address == `TWS_ADDR_OWNADDR) own_addr_ff <= writedata[9:0];
			if (wr_acc && address == `TWS_ADDR_BAUD) baud_ff <= writedata[7:0];
		end
	end

	// ==========================================
	// read mux; unimplemented bits read zero
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0000_0000;
		case (address)
			`TWS_ADDR_CONTROL: rmux[15:0] = con_ff;
			`TWS_ADDR_STATUS: rmux[15:0] = {last_ack_ff, tx_active_ff, 3'h0, coll_ff,
				gc_ff, ten_ff, wcol_ff, ovf_ff, da_ff, stop_seen_ff, start_seen_ff,
				dir_ff, rx_full_ff, tx_full_ff};
			`TWS_ADDR_MASK: rmux[9:0] = mask_ff;
			`TWS_ADDR_PAD: rmux[`TWS_PAD_LONG_DELAY] = long_delay_ff;
			`TWS_ADDR_TXBUF: rmux[7:0] = tx_buf_ff;
			`TWS_ADDR_RXBUF: rmux[7:0] = rx_buf_ff;
			`TWS_ADDR_OWNADDR: rmux[9:0] = own_addr_ff;
			`TWS_ADDR_BAUD: rmux[7:0] = baud_ff;
			default: rmux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (acc) begin
			rdata_ff <= rmux;
		end
	end
	assign readdata = rdata_ff;
endmodule

// *** bench/tws_ctrl_checker.sv ***
`timescale 1ns/1ps
`include "tws_defs.svh"
// ==========================
// port checker for the control block
module tws_ctrl_checker (
	// system
	input wire logic clock,
	input wire logic arst_n,
	// register bus
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// bus pins
	input wire logic serial_clock_pin_in,
	input wire logic serial_clock_pin_out,
	input wire logic serial_clock_pin_oe,
	input wire logic serial_data_pin_in,
	input wire logic serial_data_pin_out,
	input wire logic serial_data_pin_oe
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	// read finishing this cycle
	wire logic rd_done = read && !waitrequest;
	chk_first_wait: assert property ($rose(read || write) |-> waitrequest)
		else $error("no wait state on a new request");
	chk_one_wait: assert property ((read || write) && waitrequest ##1 (read || write)
		|-> !waitrequest) else $error("more than one wait state");
	chk_unmapped_zero: assert property (rd_done && address[1:0] != 2'h0 |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_upper_zero: assert property (rd_done |-> readdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
	chk_stat_unimpl: assert property (rd_done && address == `TWS_ADDR_STATUS
		|-> readdata[13:11] == 3'h0) else $error("status gap bits not zero");
	chk_mask_upper: assert property (rd_done && address == `TWS_ADDR_MASK
		|-> readdata[15:10] == 6'h0) else $error("mask upper bits not zero");
	chk_start_stop: assert property (rd_done && address == `TWS_ADDR_STATUS
		|-> !(readdata[4] && readdata[3])) else $error("start and stop both last");
	chk_data_hold: assert property (!(read || write) |=> $stable(readdata))
		else $error("read data moved while idle");
	chk_pins_low: assert property (!serial_data_pin_out && !serial_clock_pin_out)
		else $error("open drain pin drives high");
	// main traffic seen
	cov_status: cover property (rd_done && address == `TWS_ADDR_STATUS);
	cov_tx: cover property (write && !waitrequest && address == `TWS_ADDR_TXBUF);
	cov_drive: cover property ($rose(serial_data_pin_oe));
endmodule
bind tws_ctrl tws_ctrl_checker i_chk (.clock(clock), .arst_n(arst_n), .address(address),
	.read(read), .write(write), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .serial_clock_pin_in(serial_clock_pin_in),
	.serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
	.serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out),
	.serial_data_pin_oe(serial_data_pin_oe));

// *** bench/tws_bus_partner.sv ***
`timescale 1ns/1ps
// ==========================
// behavioural slave on the wire, answers with a fixed byte
module tws_bus_partner (
	// wire levels
	input wire logic scl,
	input wire logic sda,
	// commands from the bench
	input wire logic nack,
	input wire logic jam,
	// data line pull down and last master ack
	output logic sda_oe,
	output logic ack_seen
);
	int cnt = 0; // bit slot in the byte, 8 is the ack
	int byte_no = 0; // bytes since start
	logic rd = 1'b0; // read transfer
	logic [7:0] dat = 8'h5A; // byte returned on reads
	initial sda_oe = 1'b0;
	initial ack_seen = 1'b0;
	// start or stop: begin a frame, let the line go
	always @(sda) begin
		if (scl) begin
			cnt = 0;
			byte_no = 0;
			sda_oe = 1'b0;
		end
	end
	// collision forcing over: let the data line go at once
	always @(negedge jam) sda_oe = 1'b0;
	// sample on clock rise
	always @(posedge scl) begin
		if (cnt == 7 && byte_no == 0)
			rd = sda;
		if (cnt == 8 && rd && byte_no > 0) begin
			ack_seen = sda;
			// a nack ends the read: stop driving so a Stop can follow
			if (sda)
				rd = 1'b0;
		end
		if (cnt == 8)
			byte_no++;
		cnt = (cnt == 8) ? 0 : cnt + 1;
	end
	// change only while the clock is low
	always @(negedge scl) begin
		if (cnt == 8)
			sda_oe = (byte_no == 0 || !rd) && !nack;
		else if (rd && byte_no > 0)
			sda_oe = !dat[7 - cnt];
		else
			sda_oe = jam; // forced collision on written bits
	end
endmodule

// *** bench/tws_ctrl_bench.sv ***
`timescale 1ns/1ps
`include "tws_defs.svh"
// ==========================
// register level bench with a slave on the wire
module tws_ctrl_bench;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] address = 5'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic scl_oe, sda_oe, p_sda_oe, p_ack, nack = 1'b0, jam = 1'b0;
	int error_cnt = 0;
	int n_compared = 0;
	logic [31:0] q;
	localparam logic [15:0] EN = 16'h8000;
	// pulled up lines, low when anyone pulls
	wire logic scl = !scl_oe;
	wire logic sda = !(sda_oe || p_sda_oe);
	always #5 clock = !clock;
	tws_ctrl i_dut (.clock(clock), .arst_n(arst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.serial_clock_pin_in(scl), .serial_clock_pin_out(), .serial_clock_pin_oe(scl_oe),
		.serial_data_pin_in(sda), .serial_data_pin_out(), .serial_data_pin_oe(sda_oe));
	tws_bus_partner i_part (.scl(scl), .sda(sda), .nack(nack), .jam(jam),
		.sda_oe(p_sda_oe), .ack_seen(p_ack));
	// ==========================
	// shared tasks
	task check(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	// one avalon cycle, held until waitrequest is seen low
	task bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= {16'h0, d};
		// look at waitrequest where it is settled, then finish at the next rise
		do begin
			@(negedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		@(posedge clock);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 50)
			check(1'b1, 1'b0);
	endtask
	task rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 16'h0);
		check(q & m, e);
	endtask
	// poll a bit until it reaches a level, bounded
	task poll(input logic [4:0] a, input int b, input logic v);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 16'h0);
			n++;
		end while (q[b] !== v && n < 3000);
		check(q[b], v);
	endtask
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog, far beyond the expected length of the run
	initial begin
		#900000;
		error_cnt++;
		wrap_up;
	end
	// ==========================
	// tests
	initial begin
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		rdc(`TWS_ADDR_STATUS, 32'hFFFF, 32'h0);
		rdc(`TWS_ADDR_MASK, 32'hFFFF, 32'h0);
		rdc(`TWS_ADDR_BAUD, 32'hFF, 32'h3F);
		rdc(5'h02, 32'hFFFFFFFF, 32'h0);
		bus(1'b1, `TWS_ADDR_MASK, 16'hFFFF);
		rdc(`TWS_ADDR_MASK, 32'hFFFFFFFF, 32'h3FF);
		bus(1'b1, `TWS_ADDR_PAD, 16'h0010);
		rdc(`TWS_ADDR_PAD, 32'h10, 32'h10);
		bus(1'b1, `TWS_ADDR_PAD, 16'h0000);
		rdc(`TWS_ADDR_PAD, 32'h10, 32'h0);
		$display("registers done");
		// start, address write, busy write, ack then nack
		bus(1'b1, `TWS_ADDR_CONTROL, EN | 16'h1);
		poll(`TWS_ADDR_CONTROL, 0, 1'b0);
		rdc(`TWS_ADDR_STATUS, 32'h18, 32'h08);
		bus(1'b1, `TWS_ADDR_TXBUF, 16'hA4);
		bus(1'b1, `TWS_ADDR_TXBUF, 16'h11);
		rdc(`TWS_ADDR_STATUS, 32'h4081, 32'h4081);
		poll(`TWS_ADDR_STATUS, 14, 1'b0);
		rdc(`TWS_ADDR_STATUS, 32'h8001, 32'h0);
		bus(1'b1, `TWS_ADDR_STATUS, 16'h0);
		rdc(`TWS_ADDR_STATUS, 32'h80, 32'h0);
		nack <= 1'b1;
		bus(1'b1, `TWS_ADDR_TXBUF, 16'h33);
		poll(`TWS_ADDR_STATUS, 14, 1'b0);
		rdc(`TWS_ADDR_STATUS, 32'h8000, 32'h8000);
		nack <= 1'b0;
		$display("master write done");
		// repeated start, read two bytes, overflow, ack levels, stop
		bus(1'b1, `TWS_ADDR_CONTROL, EN | 16'h2);
		poll(`TWS_ADDR_CONTROL, 1, 1'b0);
		bus(1'b1, `TWS_ADDR_TXBUF, 16'hA5);
		poll(`TWS_ADDR_STATUS, 14, 1'b0);
		bus(1'b1, `TWS_ADDR_CONTROL, EN | 16'h8);
		poll(`TWS_ADDR_CONTROL, 3, 1'b0);
		rdc(`TWS_ADDR_STATUS, 32'h42, 32'h02);
		bus(1'b1, `TWS_ADDR_CONTROL, EN | 16'h10);
		poll(`TWS_ADDR_CONTROL, 4, 1'b0);
		check(p_ack, 1'b0);
		bus(1'b1, `TWS_ADDR_CONTROL, EN | 16'h8);
		poll(`TWS_ADDR_CONTROL, 3, 1'b0);
		rdc(`TWS_ADDR_STATUS, 32'h42, 32'h42);
		rdc(`TWS_ADDR_RXBUF, 32'hFF, 32'h5A);
		rdc(`TWS_ADDR_STATUS, 32'h2, 32'h0);
		bus(1'b1, `TWS_ADDR_CONTROL, EN | 16'h30);
		poll(`TWS_ADDR_CONTROL, 4, 1'b0);
		check(p_ack, 1'b1);
		bus(1'b1, `TWS_ADDR_CONTROL, EN | 16'h4);
		poll(`TWS_ADDR_CONTROL, 2, 1'b0);
		rdc(`TWS_ADDR_STATUS, 32'h18, 32'h10);
		bus(1'b1, `TWS_ADDR_STATUS, 16'h0);
		rdc(`TWS_ADDR_STATUS, 32'h40, 32'h0);
		$display("master read done");
		// slave holds data low against the master
		bus(1'b1, `TWS_ADDR_CONTROL, EN | 16'h1);
		poll(`TWS_ADDR_CONTROL, 0, 1'b0);
		jam <= 1'b1;
		bus(1'b1, `TWS_ADDR_TXBUF, 16'hFF);
		poll(`TWS_ADDR_STATUS, 10, 1'b1);
		jam <= 1'b0;
		bus(1'b1, `TWS_ADDR_STATUS, 16'h0);
		rdc(`TWS_ADDR_STATUS, 32'h400, 32'h0);
		arst_n <= 1'b0;
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		rdc(`TWS_ADDR_STATUS, 32'hFFFF, 32'h0);
		$display("collision done");
		wrap_up;
	end
endmodule
